// file: common/gpio_port_pkg.sv
package gpio_port_pkg;
   // sizes
   localparam int PIN_COUNT = 6;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [11:0] OFS_PIN_LEVELS = 12'h000;
   localparam logic [11:0] OFS_DIRECTION = 12'h004;
   localparam logic [11:0] OFS_LATCH = 12'h008;
   localparam logic [11:0] OFS_ANALOG = 12'h00C;
   localparam logic [11:0] OFS_STEERING = 12'h010;
   // values after reset
   localparam logic [5:0] RST_DIRECTION = 6'h3F;
   localparam logic [5:0] RST_LATCH = 6'h00;
   localparam logic [5:0] RST_ANALOG = 6'h17;
   localparam logic [7:0] RST_STEERING = 8'h00;
   // implemented bit masks
   localparam logic [5:0] ANALOG_MASK = 6'h17;
   localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
   localparam logic [7:0] STEERING_MASK = 8'h3B;
   // steering field positions
   localparam int SDO_BIT = 5;
   localparam int SS_BIT = 4;
   localparam int GATE_BIT = 3;
   localparam int LOGIC_BIT = 1;
   localparam int OSC_BIT = 0;
endpackage

// file: verilog/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw and synchronised levels
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] synced
);
   import gpio_port_pkg::*;

   // two stages; the first is read only by the second
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st;
   sync_s next_st;

   // shift one stage per edge
   always_comb begin
      next_st = st;
      next_st.meta = raw;
      next_st.stable = st.meta;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign synced = st.stable;
endmodule

// file: verilog/output_priority_mux.sv
`timescale 1ns/1ps
module output_priority_mux #(
   parameter int SOURCES = 1
) (
   // peripheral sources, index 0 highest priority
   input wire logic [SOURCES-1:0] src_val,
   input wire logic [SOURCES-1:0] src_en,
   // general purpose path
   input wire logic latch_val,
   input wire logic dir_in,
   // pin drive
   output logic pin_val,
   output logic pin_drive
);
   import gpio_port_pkg::*;

   // walk from lowest to highest so the highest enabled wins
   always_comb begin
      pin_val = latch_val;
      pin_drive = ~dir_in;
      for (int i = SOURCES - 1; i >= 0; i--) begin
         if (src_en[i]) begin
            pin_val = src_val[i];
            pin_drive = 1'b1;
         end
      end
   end
endmodule

// file: verilog/gpio_port.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module gpio_port (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [gpio_port_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpio_port_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [gpio_port_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // port a pins
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   // port c overrides and input
   input wire logic port_c_pin3,
   output logic port_c_pin1_out,
   output logic port_c_pin1_oe,
   output logic port_c_pin2_out,
   output logic port_c_pin2_oe,
   output logic port_c_pin5_out,
   output logic port_c_pin5_oe,
   // pin 0 sources
   input wire logic programming_data_line,
   input wire logic programming_data_en,
   input wire logic dac_output_one,
   input wire logic dac_output_one_en,
   // pin 2 sources
   input wire logic dac_output_two,
   input wire logic dac_output_two_en,
   input wire logic logic_cell_one_output,
   input wire logic logic_cell_one_en,
   input wire logic comparator_one_output,
   input wire logic comparator_one_en,
   input wire logic pwm_three_output,
   input wire logic pwm_three_en,
   // pin 4 sources
   input wire logic clock_out_signal,
   input wire logic clock_out_en,
   input wire logic controlled_oscillator_output,
   input wire logic controlled_oscillator_en,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en,
   // routed peripheral inputs
   output logic slave_select_in,
   output logic timer_one_gate_input
);
   import gpio_port_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   ////////////////////////////////////////////////////////////////////

   typedef struct packed {
      logic [5:0] dir;     // direction, 1 = input
      logic [5:0] lat;     // output latch
      logic [5:0] ansel;   // analog select
      logic [7:0] steer;   // alternate pin steering
      logic [31:0] rdata;  // read data for access phase
      logic slverr;        // error for access phase
   } port_s;

   port_s st;
   port_s next_st;

   logic [5:0] pin_sync;   // synchronised pin levels
   logic c3_sync;          // synchronised port c pin 3
   logic [5:0] pin_read;   // digital read value of the port
   logic setup_ph;         // apb setup cycle
   logic wr_acc;           // apb write access cycle
   logic mapped;           // address hits a register

   ////////////////////////////////////////////////////////////////////
   // helpers
   ////////////////////////////////////////////////////////////////////

   // merge write data with current pin levels per byte strobe
   function automatic logic [5:0] rmw(
      input logic [5:0] levels,
      input logic [31:0] data,
      input logic strobe
   );
      logic [5:0] res;
      res = strobe ? data[5:0] : levels;
      return res;
   endfunction

   // register hit decode
   function automatic logic hit(
      input logic [11:0] addr
   );
      logic h;
      h = (addr == OFS_PIN_LEVELS) || (addr == OFS_DIRECTION) ||
          (addr == OFS_LATCH) || (addr == OFS_ANALOG) ||
          (addr == OFS_STEERING);
      return h;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin input path
   ////////////////////////////////////////////////////////////////////

   level_sync #(
      .WIDTH(6)
   ) u_sync_a (
      .pclk(pclk),
      .presetn(presetn),
      .raw(pin_in),
      .synced(pin_sync)
   );

   level_sync #(
      .WIDTH(1)
   ) u_sync_c (
      .pclk(pclk),
      .presetn(presetn),
      .raw(port_c_pin3),
      .synced(c3_sync)
   );

   assign pin_read = pin_sync & ~(st.ansel & ANALOG_MASK);

   assign slave_select_in = st.steer[SS_BIT] ? pin_read[3] : c3_sync;
   assign timer_one_gate_input =
      st.steer[GATE_BIT] ? pin_read[3] : pin_read[4];

   ////////////////////////////////////////////////////////////////////
   // pin output path
   ////////////////////////////////////////////////////////////////////

   output_priority_mux #(
      .SOURCES(2)
   ) u_mux0 (
      .src_val({dac_output_one, programming_data_line}),
      .src_en({dac_output_one_en, programming_data_en}),
      .latch_val(st.lat[0]),
      .dir_in(st.dir[0]),
      .pin_val(pin_out[0]),
      .pin_drive(pin_oe[0])
   );

   // logic cell on A2 when route bit clear
   output_priority_mux #(
      .SOURCES(4)
   ) u_mux2 (
      .src_val({pwm_three_output, comparator_one_output,
                logic_cell_one_output, dac_output_two}),
      .src_en({pwm_three_en, comparator_one_en,
               logic_cell_one_en & ~st.steer[LOGIC_BIT],
               dac_output_two_en}),
      .latch_val(st.lat[2]),
      .dir_in(st.dir[2]),
      .pin_val(pin_out[2]),
      .pin_drive(pin_oe[2])
   );

   // serial and oscillator on A4 when bits set
   output_priority_mux #(
      .SOURCES(3)
   ) u_mux4 (
      .src_val({serial_data_out, controlled_oscillator_output,
                clock_out_signal}),
      .src_en({serial_data_out_en & st.steer[SDO_BIT],
               controlled_oscillator_en & st.steer[OSC_BIT],
               clock_out_en}),
      .latch_val(st.lat[4]),
      .dir_in(st.dir[4]),
      .pin_val(pin_out[4]),
      .pin_drive(pin_oe[4])
   );

   assign pin_out[1] = st.lat[1];
   assign pin_oe[1] = ~st.dir[1];
   assign pin_out[5] = st.lat[5];
   assign pin_oe[5] = ~st.dir[5];
   assign pin_out[3] = 1'b0;
   assign pin_oe[3] = 1'b0;

   // serial out to C2 when bit clear
   assign port_c_pin2_out = serial_data_out;
   assign port_c_pin2_oe = serial_data_out_en & ~st.steer[SDO_BIT];
   // logic cell to C5 when bit set
   assign port_c_pin5_out = logic_cell_one_output;
   assign port_c_pin5_oe = logic_cell_one_en & st.steer[LOGIC_BIT];
   // oscillator to C1 when bit clear
   assign port_c_pin1_out = controlled_oscillator_output;
   assign port_c_pin1_oe = controlled_oscillator_en & ~st.steer[OSC_BIT];

   ////////////////////////////////////////////////////////////////////
   // register file
   ////////////////////////////////////////////////////////////////////

   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign mapped = hit(paddr);

   // next state: bus writes and read capture
   always_comb begin
      next_st = st;
      // capture read data and error in setup cycle
      if (setup_ph) begin
         next_st.slverr = ~mapped;
         next_st.rdata = '0;
         case (paddr)
            OFS_PIN_LEVELS: next_st.rdata[5:0] = pin_read;
            OFS_DIRECTION: next_st.rdata[5:0] = st.dir | INPUT_ONLY_MASK;
            OFS_LATCH: next_st.rdata[5:0] = st.lat;
            OFS_ANALOG: next_st.rdata[5:0] = st.ansel & ANALOG_MASK;
            OFS_STEERING: next_st.rdata[7:0] = st.steer & STEERING_MASK;
            // unmapped reads zero
            default: next_st.rdata = '0;
         endcase
      end
      // writes take effect at the access edge
      if (wr_acc) begin
         case (paddr)
            // both data writes merge with pin levels
            OFS_PIN_LEVELS: next_st.lat = rmw(pin_read, pwdata, pstrb[0]);
            OFS_LATCH: next_st.lat = rmw(pin_read, pwdata, pstrb[0]);
            // pin three direction held at one
            OFS_DIRECTION: begin
               if (pstrb[0]) begin
                  next_st.dir = pwdata[5:0] | INPUT_ONLY_MASK;
               end
            end
            OFS_ANALOG: begin
               if (pstrb[0]) begin
                  next_st.ansel = pwdata[5:0] & ANALOG_MASK;
               end
            end
            // steering write touches no direction bit
            OFS_STEERING: begin
               if (pstrb[0]) begin
                  next_st.steer = pwdata[7:0] & STEERING_MASK;
               end
            end
            // unmapped writes ignored
            default: next_st = next_st;
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.dir <= RST_DIRECTION;
         st.lat <= RST_LATCH;
         st.ansel <= RST_ANALOG;
         st.steer <= RST_STEERING;
         st.rdata <= '0;
         st.slverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // zero-wait slave
   assign pready = 1'b1;
   assign prdata = st.rdata;
   assign pslverr = st.slverr & psel & penable;

   ////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_pin3_input;
      !pin_oe[3] && (st.dir[3] == 1'b1);
   endproperty
   a_pin3_input: assert property (p_pin3_input)
      else $error("pin three driven or direction cleared");

   property p_dir_off;
      st.dir[1] |-> !pin_oe[1];
   endproperty
   a_dir_off: assert property (p_dir_off)
      else $error("input pin one still driven");

   property p_dir_drive;
      !st.dir[5] |-> pin_oe[5] && (pin_out[5] == st.lat[5]);
   endproperty
   a_dir_drive: assert property (p_dir_drive)
      else $error("output pin five not driving latch");

   property p_latch_write;
      (wr_acc && paddr == OFS_LATCH && pstrb[0])
         |=> st.lat == $past(pwdata[5:0]);
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("latch write lost");

   property p_rmw;
      (wr_acc && paddr == OFS_PIN_LEVELS && !pstrb[0])
         |=> st.lat == $past(pin_read);
   endproperty
   a_rmw: assert property (p_rmw)
      else $error("unstrobed level write did not keep pin levels");

   property p_analog_zero;
      (setup_ph && paddr == OFS_PIN_LEVELS && st.ansel[0])
         |=> prdata[0] == 1'b0;
   endproperty
   a_analog_zero: assert property (p_analog_zero)
      else $error("analog pin read as one");

   property p_prog_wins;
      programming_data_en
         |-> pin_oe[0] && (pin_out[0] == programming_data_line);
   endproperty
   a_prog_wins: assert property (p_prog_wins)
      else $error("programming data lost pin zero");

   property p_steer_dir;
      (wr_acc && paddr == OFS_STEERING) |=> $stable(st.dir);
   endproperty
   a_steer_dir: assert property (p_steer_dir)
      else $error("steering write changed direction");

   property p_steer_spare;
      (setup_ph && paddr == OFS_STEERING)
         |=> prdata[7:6] == 2'b00 && prdata[2] == 1'b0;
   endproperty
   a_steer_spare: assert property (p_steer_spare)
      else $error("spare steering bits read nonzero");

   property p_sdo_route;
      (serial_data_out_en && !st.steer[SDO_BIT] && !clock_out_en
         && !(controlled_oscillator_en && st.steer[OSC_BIT])
         && st.dir[4])
         |-> port_c_pin2_oe && !pin_oe[4];
   endproperty
   a_sdo_route: assert property (p_sdo_route)
      else $error("serial out not routed to port c");
endmodule

// file: verification/pin_world.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// outside world of port a: each pin shows the design's drive while its
// driver is on, otherwise the level that the board presents
module pin_world (
   // design drive
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   // board levels on undriven pins
   input wire logic [5:0] ext_level,
   // resolved pin levels
   output logic [5:0] pin_in
);
   // wire resolution, driver wins over board level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// file: verification/gpio_port_tb.sv
`timescale 1ns/1ps
module gpio_port_tb;
   import gpio_port_pkg::*;
   // one row: write, then read back
   typedef struct packed {
      logic [11:0] wa;
      logic [31:0] wd;
      logic [11:0] ra;
      logic [31:0] ex;
   } row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [5:0] pin_in, pin_out, pin_oe, ext_level;
   logic [8:0] src_val, src_en;
   logic port_c_pin3, c1_oe, c2_oe, c5_oe, ss_in, gate_in, er;
   logic c1_out, c2_out, c5_out;
   int err_count = 0;
   int samples_checked = 0;
   row_s rows [0:6] = '{
      '{OFS_DIRECTION, 32'h0, OFS_DIRECTION, 32'h8},
      '{OFS_ANALOG, 32'hFF, OFS_ANALOG, 32'h17},
      '{OFS_ANALOG, 32'h2, OFS_ANALOG, 32'h2},
      '{OFS_STEERING, 32'hFF, OFS_STEERING, 32'h3B},
      '{OFS_LATCH, 32'h2A, OFS_LATCH, 32'h2A},
      '{OFS_PIN_LEVELS, 32'h15, OFS_LATCH, 32'h15},
      '{12'h020, 32'h3F, 12'h020, 32'h0}};

   ////////////////////////////////////////////////////////////////////
   // clock, 5 ns period
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   pin_world world (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));

   gpio_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .port_c_pin3(port_c_pin3),
      .port_c_pin1_out(c1_out), .port_c_pin1_oe(c1_oe),
      .port_c_pin2_out(c2_out), .port_c_pin2_oe(c2_oe),
      .port_c_pin5_out(c5_out), .port_c_pin5_oe(c5_oe),
      .programming_data_line(src_val[0]), .programming_data_en(src_en[0]),
      .dac_output_one(src_val[1]), .dac_output_one_en(src_en[1]),
      .dac_output_two(src_val[2]), .dac_output_two_en(src_en[2]),
      .logic_cell_one_output(src_val[3]), .logic_cell_one_en(src_en[3]),
      .comparator_one_output(src_val[4]), .comparator_one_en(src_en[4]),
      .pwm_three_output(src_val[5]), .pwm_three_en(src_en[5]),
      .clock_out_signal(src_val[6]), .clock_out_en(src_en[6]),
      .controlled_oscillator_output(src_val[7]),
      .controlled_oscillator_en(src_en[7]),
      .serial_data_out(src_val[8]), .serial_data_out_en(src_en[8]),
      .slave_select_in(ss_in), .timer_one_gate_input(gate_in));

   ////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // write a register, let combinational outputs settle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
      #1;
   endtask

   // read a register and compare
   task automatic rdc(input string nm, input logic [11:0] a,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(nm, e, rd);
   endtask

   // each source of a pin beats every lower one
   task automatic prio(input int lo, input int hi, input int p);
      logic [8:0] m;
      for (int k = lo; k <= hi; k++) begin
         m = (9'h1FF << k) & ~(9'h1FF << (hi + 1));
         @(posedge pclk);
         src_en <= m;
         src_val <= 9'h001 << k;
         @(posedge pclk);
         #1;
         chk("prio_one", 32'h3, {30'h0, pin_out[p], pin_oe[p]});
         @(posedge pclk);
         src_val <= ~(9'h001 << k);
         @(posedge pclk);
         #1;
         chk("prio_zero", 32'h1, {30'h0, pin_out[p], pin_oe[p]});
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #100000;
      err_count++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, port_c_pin3} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      src_val = 9'h000;
      src_en = 9'h000;
      ext_level = 6'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // table of register write and read back
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         apb(1'b0, rows[i].ra, 32'h0, 4'h0);
         chk("reg_row", rows[i].ex, rd);
         chk("slverr", {31'h0, rows[i].ra == 12'h020}, {31'h0, er});
      end
      // reset again in mid run
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rdc("dir_rst", OFS_DIRECTION, 32'h3F);
      rdc("ana_rst", OFS_ANALOG, 32'h17);
      rdc("steer_rst", OFS_STEERING, 32'h0);
      chk("oe_rst", 32'h0, {26'h0, pin_oe});
      // latch drives outputs, pin three never driven
      wr(OFS_ANALOG, 32'h0);
      wr(OFS_DIRECTION, 32'h0);
      wr(OFS_LATCH, 32'h3F);
      chk("oe_out", 32'h37, {26'h0, pin_oe});
      chk("out_val", 32'h37, {26'h0, pin_out & pin_oe});
      // driven levels need two sync edges before the read capture
      repeat (3) @(posedge pclk);
      rdc("lvl_drv", OFS_PIN_LEVELS, 32'h37);
      // data write without strobe copies pin levels into latch
      wr(OFS_DIRECTION, 32'h3F);
      ext_level <= 6'h2D;
      repeat (3) @(posedge pclk);
      apb(1'b1, OFS_PIN_LEVELS, 32'h0, 4'h0);
      rdc("rmw", OFS_LATCH, 32'h2D);
      // analog pins read zero but still drive
      wr(OFS_ANALOG, 32'h17);
      ext_level <= 6'h3F;
      repeat (3) @(posedge pclk);
      rdc("lvl_ana", OFS_PIN_LEVELS, 32'h28);
      wr(OFS_DIRECTION, 32'h0);
      wr(OFS_LATCH, 32'h3F);
      chk("oe_ana", 32'h37, {26'h0, pin_oe});
      // source priority, drivers forced on over inputs in analog mode
      wr(OFS_DIRECTION, 32'h3F);
      wr(OFS_STEERING, 32'h21);
      prio(0, 1, 0);
      prio(2, 5, 2);
      prio(6, 8, 4);
      // output steering between port a and port c
      @(posedge pclk);
      src_en <= 9'h188;
      src_val <= 9'h1FF;
      wr(OFS_STEERING, 32'h0);
      chk("steer0", 32'h1A, {27'h0, c1_oe, c2_oe, c5_oe, pin_oe[2],
         pin_oe[4]});
      wr(OFS_STEERING, 32'h23);
      chk("steer1", 32'h05, {27'h0, c1_oe, c2_oe, c5_oe, pin_oe[2],
         pin_oe[4]});
      rdc("dir_kept", OFS_DIRECTION, 32'h3F);
      // port c drive values follow their peripheral sources
      chk("c_out1", 32'h7, {29'h0, c1_out, c2_out, c5_out});
      src_val <= 9'h000;
      @(posedge pclk);
      #1;
      chk("c_out0", 32'h0, {29'h0, c1_out, c2_out, c5_out});
      @(posedge pclk);
      // input steering of slave select and timer gate
      src_en <= 9'h000;
      wr(OFS_ANALOG, 32'h0);
      ext_level <= 6'h08;
      repeat (3) @(posedge pclk);
      wr(OFS_STEERING, 32'h0);
      chk("in_steer0", 32'h0, {30'h0, ss_in, gate_in});
      wr(OFS_STEERING, 32'h18);
      chk("in_steer1", 32'h3, {30'h0, ss_in, gate_in});
      final_report();
   end
endmodule
